// ### shared/adc_ctrl_regs.vh
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// ************************************************************
// Timing of the block clock and the internal conversion clock
// ************************************************************
`define CORE_CLK_PERIOD_NS 4
`define INTCLK_PERIOD_NS 800
`define INTCLK_CYCLES (`INTCLK_PERIOD_NS / `CORE_CLK_PERIOD_NS)
`define STROBE_LOW_MAX_NS 15000

// ************************************************************
// Control byte: positions in the full byte
// ************************************************************
`define CTRL_MODE_HI 1
`define CTRL_MODE_LO 0

// Positions in the six-bit snapshot taken at the sixth bit
`define SNAP_BIP 0
`define SNAP_RNG 1
`define SNAP_SEL_LO 2
`define SNAP_SEL_HI 4

// Bit counter values: sixth bit and last bit of the byte
`define BIT_ACQ_START 3'h5
`define BIT_LAST 3'h7
`define BIT_AFTER_START 3'h1
`define CTRL_START_SEED 8'h01

// ************************************************************
// Sequencing counts
// ************************************************************
`define ACQ_EXT_LAST 3'h5
`define INT_ACQ_LAST_TICK 5'h03
`define RES_MSB 4'hB
`define RES_BIT6 4'h6
`define RES_LSB 4'h0
`define RES_RESET 12'h000

`endif

// ### verilog/sync_2ff.v
`timescale 1ns/10ps
// Two-stage synchroniser for levels arriving from outside core_clk
module sync_2ff
#(
  parameter WIDTH = 3
)
(
  input wire core_clk, // Block clock
  input wire sys_rst, // Synchronous reset, active high
  input wire [WIDTH-1:0] asyncIn, // Unsynchronised levels
  input wire [WIDTH-1:0] resetValue, // Idle level of each input
  output reg [WIDTH-1:0] syncOut // Synchronised levels
);

  reg [WIDTH-1:0] stage1;

  // First stage feeds only the second stage to contain metastability.
  // Reset loads the idle level so no false edge follows reset.
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      stage1 <= resetValue;
      syncOut <= resetValue;
    end
    else
    begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end

endmodule

// ### verilog/adc_serial_conversion_control.v
//
// Functional notes
// - Range and polarity bits pick four spans
// - Sample control bits on rising clock, select low
// - Idle: first one after select falls starts
// - During conversion, start accepted after bit six
// - Result bits shift out on falling edges, MSB first
// - Unipolar straight binary, bipolar two's complement
// - Select fall alone never starts a conversion
// - Acquire from sixth bit, six clocks, then convert
// - Early start bit abandons current conversion
// - External mode: strobe high one serial clock
// - External mode: twelve decisions, then zeros
// - External mode: float when deselected, low after
// - Back-to-back external conversions in eighteen clocks
// - Internal mode: strobe low, high when done
// - Internal: convert at tick four, end tick sixteen
// - Internal: strobe low at most fifteen microseconds
// - Internal: result held, MSB at last tick
// - Internal: deselect floats data, conversion continues
// - Control byte layout start, channel, range, polarity
// - Mode field: internal, external, standby, full down
// - Power-up: active, internal mode, result cleared
// - Power-down after conversion; start bit wakes
//
`timescale 1ns/10ps
`include "adc_ctrl_regs.vh"

module adc_serial_conversion_control
#(
  parameter INT_DIV = `INTCLK_CYCLES,
  parameter RES_WIDTH = 12
)
(
  input wire core_clk, // Block clock, 250 MHz
  input wire sys_rst, // Synchronous reset, active high
  input wire chipSelectN, // Chip select pin, active low
  input wire serialClock, // Host serial clock pin
  input wire serialDataIn, // Host serial data pin
  input wire compareHigh, // Comparator: input at or above trial
  output reg serialDataOut, // Serial result data
  output reg serialDataOutEn, // High while data pin is driven
  output reg conversionStrobe, // Conversion strobe
  output reg conversionStrobeEn, // High while strobe pin is driven
  output reg [RES_WIDTH-1:0] trialCode, // Trial code to the DAC
  output reg holdSample, // High: hold and convert, low: track
  output reg [2:0] channelSelect, // Selected input channel
  output reg rangeSelect, // High: larger full-scale span
  output reg polaritySelect, // High: bipolar span
  output reg standbyPowerdown, // Standby power-down active
  output reg fullPowerdown // Full power-down active
);

  // ************************************************************
  // States and helpers
  // ************************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ACQ_EXT = 3'h1;
  localparam [2:0] ST_CONV_EXT = 3'h2;
  localparam [2:0] ST_ACQ_INT = 3'h3;
  localparam [2:0] ST_CONV_INT = 3'h4;
  localparam [15:0] DIV_LAST = INT_DIV - 1;

  // Returns v with bit i replaced by b
  function [RES_WIDTH-1:0] setBit;
    input [RES_WIDTH-1:0] v;
    input [3:0] i;
    input b;
    integer k;
    begin
      setBit = v;
      for (k = 0; k < RES_WIDTH; k = k + 1)
      begin
        if (k == i)
          setBit[k] = b;
      end
    end
  endfunction

  // ************************************************************
  // Pin synchronisation and edge detection
  // ************************************************************
  wire [2:0] pinSync;
  wire csNS;
  wire sclkS;
  wire sdiS;
  reg csPrev;
  reg sclkPrev;

  sync_2ff #(.WIDTH(3)) pinSyncInst
  (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .asyncIn({chipSelectN, serialClock, serialDataIn}),
    .resetValue(3'h4),
    .syncOut(pinSync)
  );

  assign csNS = pinSync[2];
  assign sclkS = pinSync[1];
  assign sdiS = pinSync[0];

  wire sclkRise = sclkS & ~sclkPrev;
  wire sclkFall = ~sclkS & sclkPrev;
  wire csFall = ~csNS & csPrev;

  // ************************************************************
  // Sequencer state
  // ************************************************************
  reg [2:0] state;
  reg receiving;
  reg [2:0] recvCnt;
  reg [7:0] ctrlShift;
  reg extMode; // Clock mode in effect
  reg convExt; // Clock mode of the running conversion
  reg convBipolar;
  reg acqPendExt;
  reg intPend;
  reg pastBit6;
  reg csRefell;
  reg pendStandby;
  reg pendFull;
  reg [2:0] acqCnt;
  reg [15:0] divCnt;
  reg [4:0] tickCnt;
  reg [3:0] bitIdx;
  reg [RES_WIDTH-1:0] sarCode;
  reg [RES_WIDTH-1:0] resultReg;
  reg [RES_WIDTH-1:0] outShift;

  wire [7:0] shiftNext = {ctrlShift[6:0], sdiS};
  wire intTick = (divCnt == DIV_LAST);
  wire intBusy = (state == ST_ACQ_INT) | (state == ST_CONV_INT);

  // Successive-approximation decision for the current bit
  wire [RES_WIDTH-1:0] decided = setBit(sarCode, bitIdx, compareHigh);
  // Offset binary becomes two's complement by flipping the MSB
  wire [RES_WIDTH-1:0] converted =
    {decided[RES_WIDTH-1] ^ convBipolar, decided[RES_WIDTH-2:0]};
  wire sarOutBit = (bitIdx == `RES_MSB) ? converted[RES_WIDTH-1] :
    compareHigh;

  // Start hunting: idle, after a fresh select fall, or past bit six
  wire hunting = ~receiving &
    ((state == ST_IDLE) | csRefell | pastBit6);

  // ************************************************************
  // Main process: pins, control byte, acquisition, conversion
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      csPrev <= 1'b1;
      sclkPrev <= 1'b0;
      serialDataOut <= 1'b0;
      serialDataOutEn <= 1'b0;
      conversionStrobe <= 1'b1;
      conversionStrobeEn <= 1'b1;
      trialCode <= `RES_RESET;
      holdSample <= 1'b0;
      channelSelect <= 3'h0;
      rangeSelect <= 1'b0;
      polaritySelect <= 1'b0;
      standbyPowerdown <= 1'b0;
      fullPowerdown <= 1'b0;
      state <= ST_IDLE;
      receiving <= 1'b0;
      recvCnt <= 3'h0;
      ctrlShift <= 8'h00;
      extMode <= 1'b0;
      convExt <= 1'b0;
      convBipolar <= 1'b0;
      acqPendExt <= 1'b0;
      intPend <= 1'b0;
      pastBit6 <= 1'b0;
      csRefell <= 1'b0;
      pendStandby <= 1'b0;
      pendFull <= 1'b0;
      acqCnt <= 3'h0;
      divCnt <= 16'h0000;
      tickCnt <= 5'h00;
      bitIdx <= `RES_MSB;
      sarCode <= `RES_RESET;
      resultReg <= `RES_RESET;
      outShift <= `RES_RESET;
    end
    else
    begin
      csPrev <= csNS;
      sclkPrev <= sclkS;
      // Data pin floats whenever deselected, in both modes
      serialDataOutEn <= ~csNS;
      // Strobe floats only in external mode, never while an internal
      // conversion runs, whatever clock mode the last byte chose
      conversionStrobeEn <= (extMode & ~intBusy) ? ~csNS : 1'b1;
      if (csFall & (state != ST_IDLE))
        csRefell <= 1'b1;
      // External mode drives both pins low after a select fall; an
      // internal result still waiting to be read keeps its first bit
      if (csFall & extMode)
      begin
        if (convExt)
          serialDataOut <= 1'b0;
        conversionStrobe <= 1'b0;
      end

      // Internal clock runs only while an internal conversion is on;
      // it keeps going with select high so the result is not lost
      if ((state == ST_ACQ_INT) | (state == ST_CONV_INT))
      begin
        divCnt <= intTick ? 16'h0000 : divCnt + 16'h0001;
        if (intTick)
        begin
          tickCnt <= tickCnt + 5'h01;
          if (state == ST_ACQ_INT)
          begin
            if (tickCnt == `INT_ACQ_LAST_TICK)
            begin
              state <= ST_CONV_INT;
              holdSample <= 1'b1;
              bitIdx <= `RES_MSB;
              sarCode <= `RES_RESET;
              trialCode <= setBit(`RES_RESET, `RES_MSB, 1'b1);
            end
          end
          else
          begin
            // Twelve ticks resolve twelve bits, last one at tick 16
            sarCode <= decided;
            bitIdx <= bitIdx - 4'h1;
            trialCode <= setBit(decided, bitIdx - 4'h1, 1'b1);
            if (bitIdx == `RES_LSB)
            begin
              resultReg <= converted;
              serialDataOut <= converted[RES_WIDTH-1];
              outShift <= {converted[RES_WIDTH-2:0], 1'b0};
              conversionStrobe <= 1'b1;
              holdSample <= 1'b0;
              state <= ST_IDLE;
              standbyPowerdown <= pendStandby;
              fullPowerdown <= pendFull;
              pendStandby <= 1'b0;
              pendFull <= 1'b0;
              pastBit6 <= 1'b0;
              csRefell <= 1'b0;
            end
          end
        end
      end

      // Falling serial edges drive output data and external timing
      if (sclkFall & ~csNS)
      begin
        case (state)
          ST_ACQ_EXT:
          begin
            if (acqCnt == `ACQ_EXT_LAST)
            begin
              state <= ST_CONV_EXT;
              conversionStrobe <= 1'b1;
              holdSample <= 1'b1;
              bitIdx <= `RES_MSB;
              sarCode <= `RES_RESET;
              trialCode <= setBit(`RES_RESET, `RES_MSB, 1'b1);
            end
            else
              acqCnt <= acqCnt + 3'h1;
          end
          ST_CONV_EXT:
          begin
            conversionStrobe <= 1'b0;
            serialDataOut <= sarOutBit;
            sarCode <= decided;
            bitIdx <= bitIdx - 4'h1;
            trialCode <= setBit(decided, bitIdx - 4'h1, 1'b1);
            if (bitIdx == `RES_BIT6)
              pastBit6 <= 1'b1;
            if (bitIdx == `RES_LSB)
            begin
              resultReg <= converted;
              outShift <= `RES_RESET;
              holdSample <= 1'b0;
              state <= ST_IDLE;
              standbyPowerdown <= pendStandby;
              fullPowerdown <= pendFull;
              pendStandby <= 1'b0;
              pendFull <= 1'b0;
              pastBit6 <= 1'b0;
              csRefell <= 1'b0;
            end
          end
          ST_ACQ_INT, ST_CONV_INT:
          begin
            // Host should hold the clock still here; edges are ignored
            serialDataOut <= serialDataOut;
          end
          default:
          begin
            // Idle: shift the held result out, then zeros
            serialDataOut <= outShift[RES_WIDTH-1];
            outShift <= {outShift[RES_WIDTH-2:0], 1'b0};
          end
        endcase
        // A pending acquisition wins over the end of an old conversion
        if (acqPendExt)
        begin
          state <= ST_ACQ_EXT;
          acqPendExt <= 1'b0;
          acqCnt <= 3'h0;
          holdSample <= 1'b0;
          convBipolar <= polaritySelect;
        end
        if (intPend)
        begin
          state <= ST_ACQ_INT;
          intPend <= 1'b0;
          conversionStrobe <= 1'b0;
          divCnt <= 16'h0000;
          tickCnt <= 5'h00;
          holdSample <= 1'b0;
          convBipolar <= polaritySelect;
        end
      end

      // Rising serial edges capture the control byte, select low only
      if (sclkRise & ~csNS)
      begin
        if (receiving)
        begin
          ctrlShift <= shiftNext;
          recvCnt <= recvCnt + 3'h1;
          if (recvCnt == `BIT_ACQ_START)
          begin
            // Sixth bit: channel, range and polarity are all in
            channelSelect <=
              shiftNext[`SNAP_SEL_HI:`SNAP_SEL_LO];
            rangeSelect <= shiftNext[`SNAP_RNG];
            polaritySelect <= shiftNext[`SNAP_BIP];
            convExt <= extMode;
            if (extMode)
              acqPendExt <= 1'b1;
          end
          if (recvCnt == `BIT_LAST)
          begin
            receiving <= 1'b0;
            if (~shiftNext[`CTRL_MODE_HI])
              extMode <= shiftNext[`CTRL_MODE_LO];
            else
            begin
              // Power-down codes leave the clock mode alone
              pendStandby <= ~shiftNext[`CTRL_MODE_LO];
              pendFull <= shiftNext[`CTRL_MODE_LO];
            end
            if (~convExt)
              intPend <= 1'b1;
          end
        end
        else if (hunting & sdiS)
        begin
          // Start bit: only a one starts a byte, never the select fall
          receiving <= 1'b1;
          recvCnt <= `BIT_AFTER_START;
          ctrlShift <= `CTRL_START_SEED;
          standbyPowerdown <= 1'b0;
          fullPowerdown <= 1'b0;
          csRefell <= 1'b0;
          if (~((state == ST_CONV_EXT) & pastBit6))
          begin
            // Before bit six the running conversion is dropped
            state <= ST_IDLE;
            holdSample <= 1'b0;
            acqPendExt <= 1'b0;
            intPend <= 1'b0;
            pastBit6 <= 1'b0;
            if (~extMode)
              conversionStrobe <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ### dv/adc_serial_conversion_control_props.sv
`timescale 1ns/10ps
// ********************************
// Checker on the converter pins
// ********************************
module adc_serial_conversion_control_props
#(
  parameter INT_DIV = 200,
  parameter RES_WIDTH = 12
)
(
  input wire core_clk, // Clock
  input wire sys_rst, // Reset
  input wire chipSelectN, // Select
  input wire serialClock, // Serial clock
  input wire serialDataIn, // Serial in
  input wire compareHigh, // Comparator
  input wire serialDataOut, // Serial out
  input wire serialDataOutEn, // Out enable
  input wire conversionStrobe, // Strobe
  input wire conversionStrobeEn, // Strobe enable
  input wire [RES_WIDTH-1:0] trialCode, // Trial code
  input wire holdSample, // Hold
  input wire [2:0] channelSelect, // Channel
  input wire rangeSelect, // Range
  input wire polaritySelect, // Polarity
  input wire standbyPowerdown, // Standby
  input wire fullPowerdown // Full down
);
  localparam int ACQ_LO = 3 * INT_DIV;
  localparam int ACQ_HI = 4 * INT_DIV + 8;
  localparam int END_LO = 15 * INT_DIV;
  localparam int END_HI = 16 * INT_DIV + 8;
  logic prevStrobe;
  logic intRun;
  logic [15:0] intCnt;
  wire intStart = prevStrobe && !conversionStrobe && !holdSample;

  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Cycles since an internal strobe fell; a counter, as ticks run long.
  // A strobe rise only ends a conversion that a strobe fall began.
  always @(posedge core_clk)
  begin
    prevStrobe <= conversionStrobe;
    if (sys_rst || intStart)
      intCnt <= 16'h0000;
    else if (intCnt != 16'hFFFF)
      intCnt <= intCnt + 16'h0001;
    if (sys_rst || (conversionStrobe && !prevStrobe))
      intRun <= 1'b0;
    else if (intStart)
      intRun <= 1'b1;
  end

  sel_float_a: assert property (
    chipSelectN [*6] |-> !serialDataOutEn)
    else $error("data pin driven while deselected");
  sel_drive_a: assert property (
    (!chipSelectN) [*6] |-> serialDataOutEn && conversionStrobeEn)
    else $error("pins not driven while selected");
  strobe_pulse_a: assert property (
    $rose(conversionStrobe) && holdSample
    |=> conversionStrobe [*6] ##[1:2] !conversionStrobe)
    else $error("external strobe not one serial clock");
  sar_start_a: assert property (
    $rose(holdSample) |-> trialCode == {1'b1, {(RES_WIDTH-1){1'b0}}})
    else $error("conversion did not start at mid code");
  acq_ticks_a: assert property (
    $rose(holdSample) && !conversionStrobe
    |-> intCnt >= ACQ_LO && intCnt <= ACQ_HI)
    else $error("internal acquisition length wrong");
  conv_ticks_a: assert property (
    $rose(conversionStrobe) && !holdSample && intRun
    |-> intCnt >= END_LO && intCnt <= END_HI)
    else $error("internal strobe low time wrong");
  reset_vals_a: assert property (
    $past(sys_rst) |-> conversionStrobe &&
    !serialDataOut && !holdSample && trialCode == '0 &&
    !standbyPowerdown && !fullPowerdown)
    else $error("wrong state after reset");
  cfg_hold_a: assert property (
    (chipSelectN || !serialClock) [*4] |-> $stable(channelSelect) &&
    $stable(rangeSelect) && $stable(polaritySelect))
    else $error("control bits taken without a selected rise");
  pd_one_a: assert property (!(standbyPowerdown && fullPowerdown))
    else $error("both power-down modes active");
  pd_idle_a: assert property (standbyPowerdown || fullPowerdown
    |-> !holdSample)
    else $error("powered down during conversion");

  cover property ($rose(conversionStrobe) && holdSample);
  cover property ($rose(conversionStrobe) && !holdSample);
  cover property ($rose(standbyPowerdown));
  cover property ($rose(fullPowerdown));
endmodule

bind adc_serial_conversion_control adc_serial_conversion_control_props
  #(.INT_DIV(INT_DIV), .RES_WIDTH(RES_WIDTH)) u_props
(
  .core_clk, .sys_rst, .chipSelectN, .serialClock, .serialDataIn,
  .compareHigh, .serialDataOut, .serialDataOutEn, .conversionStrobe,
  .conversionStrobeEn, .trialCode, .holdSample, .channelSelect,
  .rangeSelect, .polaritySelect, .standbyPowerdown, .fullPowerdown
);

// ### dv/serial_host_model.sv
`timescale 1ns/10ps
// Mode-0 serial host with a 32 ns clock that stands low between frames
module serial_host_model
(
  output logic chipSelectN, // Select, active low
  output logic serialClock, // Serial clock
  output logic serialDataIn, // Data to the converter
  input wire logic serialDataOut, // Data from the converter
  input wire logic serialDataOutEn, // Data pin driven
  output logic [31:0] rxWord, // Bits read in a frame
  output logic rxDone // Pulse after a read frame
);
  // Idle: deselected, clock still
  initial
  begin
    chipSelectN = 1'b1;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
    rxWord = 32'h0;
    rxDone = 1'b0;
  end

  // Select edge, then a gap before any clock
  task automatic sel(input logic v);
    #8 chipSelectN = v;
    #8;
  endtask

  // Byte on the first rises, zeros after; sample just before each fall
  task automatic clocks(input logic [7:0] ctrl, input int n, input logic rd);
    rxWord = 32'h0;
    for (int i = 0; i < n; i++)
    begin
      serialDataIn = (i < 8) ? ctrl[7 - i] : 1'b0;
      #16 serialClock = 1'b1;
      // A floating data pin reads as the inverse of its last level
      #15 rxWord = {rxWord[30:0], serialDataOutEn ? serialDataOut :
        ~serialDataOut};
      #1 serialClock = 1'b0;
    end
    // A released line must not look like it still holds its last bit
    serialDataIn = ~serialDataIn;
    if (rd)
    begin
      rxDone = 1'b1;
      #1 rxDone = 1'b0;
    end
  endtask
endmodule

// ### dv/adc_serial_conversion_control_bench.sv
`timescale 1ns/10ps
module adc_serial_conversion_control_bench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic compareHigh = 1'b0;
  logic [11:0] ain = 12'h000;
  logic curExt = 1'b0;
  logic [12:0] expQ[$];
  logic [1:0] modes[10] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h1, 2'h2,
    2'h3, 2'h0, 2'h2};
  integer seed = 67648;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  wire chipSelectN, serialClock, serialDataIn, serialDataOut;
  wire serialDataOutEn, conversionStrobe, conversionStrobeEn, holdSample;
  wire rangeSelect, polaritySelect, standbyPowerdown, fullPowerdown;
  wire rxDone;
  wire [11:0] trialCode;
  wire [2:0] channelSelect;
  wire [31:0] rxWord;

  // Short internal tick keeps the run brief
  adc_serial_conversion_control #(.INT_DIV(4)) u_adc_serial_conversion_control
  (
    .core_clk, .sys_rst, .chipSelectN, .serialClock, .serialDataIn,
    .compareHigh, .serialDataOut, .serialDataOutEn, .conversionStrobe,
    .conversionStrobeEn, .trialCode, .holdSample, .channelSelect,
    .rangeSelect, .polaritySelect, .standbyPowerdown, .fullPowerdown
  );

  serial_host_model u_serial_host_model
  (
    .chipSelectN, .serialClock, .serialDataIn, .serialDataOut,
    .serialDataOutEn, .rxWord, .rxDone
  );

  // Block clock, 250 MHz
  initial
    forever #2 core_clk = ~core_clk;

  // Comparator stand-in: analog level held as an offset-binary code
  always @(negedge core_clk)
    compareHigh <= (ain >= trialCode);

  task automatic miss(input string m);
    fail_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic cmpWord(input logic [12:0] got, input logic [12:0] exp);
    checks_done++;
    if (got !== exp)
      miss($sformatf("word %h, want %h", got, exp));
  endtask

  task automatic cmpFlag(input logic [6:0] got, input logic [6:0] exp);
    checks_done++;
    if (got !== exp)
      miss($sformatf("flags %b, want %b", got, exp));
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Each word read takes the oldest note
  always @(posedge rxDone)
    if (expQ.size() == 0)
      miss("word with no note");
    else
      cmpWord(rxWord[12:0], expQ.pop_front());

  // Hang guard
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miss("run timed out");
      report_and_stop();
    end
  end

  // One conversion in the clock mode now in effect
  task automatic conv(input logic [1:0] md, input logic [1:0] rb);
    logic [2:0] ch;
    logic [1:0] pd;
    logic ext;
    int r;
    int n;
    r = $random(seed);
    ch = r[2:0];
    ain = r[14:3];
    ext = curExt;
    pd = {md == 2'h2, md == 2'h3};
    expQ.push_back({rb[0] ? ain ^ 12'h800 : ain, 1'b0});
    u_serial_host_model.sel(1'b0);
    n = ext ? 26 : 8;
    u_serial_host_model.clocks({1'b1, ch, rb, md}, n, ext);
    cmpFlag({channelSelect, rangeSelect, polaritySelect, standbyPowerdown,
      fullPowerdown}, {ch, rb, ext ? pd : 2'h0});
    if (!ext)
    begin
      // Deselected with the clock still while converting
      u_serial_host_model.sel(1'b1);
      n = 0;
      while (n < 400 && !(n > 8 && conversionStrobe === 1'b1))
      begin
        @(negedge core_clk);
        n++;
      end
      if (n == 400)
        miss("no end of conversion");
      u_serial_host_model.sel(1'b0);
      u_serial_host_model.clocks(8'h00, 13, 1'b1);
    end
    // The mode field is in effect once the byte is in
    if (md == 2'h0)
      curExt = 1'b0;
    else if (md == 2'h1)
      curExt = 1'b1;
    u_serial_host_model.sel(1'b1);
    repeat (8) @(negedge core_clk);
    cmpFlag({3'h0, serialDataOutEn, conversionStrobeEn, standbyPowerdown,
      fullPowerdown}, {4'h0, !curExt, pd});
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge core_clk);
    cmpFlag({conversionStrobe, serialDataOut, holdSample, standbyPowerdown,
      fullPowerdown, trialCode[1:0]}, 7'h40);
    u_serial_host_model.sel(1'b0);
    repeat (40) @(negedge core_clk);
    cmpFlag({conversionStrobe, holdSample, 5'h00}, 7'h40);
    u_serial_host_model.sel(1'b1);
    $display("reset and select-only test done");
    for (int i = 0; i < 10; i++)
    begin
      conv(modes[i], i[1:0]);
      $display("conversion %0d done", i);
    end
    report_and_stop();
  end
endmodule
